// File: design/pfs_pin_function_select.sv
`timescale 1ns/1ps
// Notes on behaviour
// - bit 0 enables the pin's general io function; clear after reset
// - port-1 bit 1 makes the pin a source of pin interrupt zero
// - port-1 bit 2 makes the pin a source of pin interrupt one
// - many pins per interrupt, one pin may feed both interrupts
// - touch sensing needs bit 7 and the pin's analog enable together
// - p1.1: enhanced tx, uart_zero tx, capture channel 5, spi select
// - p1.2: touch 10, i2c master sda, slave2 sda, pwm0, spi mosi
// - p1.3: touch 11, master scl, slave2 scl, pwm1, spi select
// - p1.4: touch 12, master sda, slave2 sda, buzzer, spi miso
// - p1.5: touch 13, master scl, slave2 scl, pwm1, spi clock
// - p1.6: touch 14, enhanced rx, uart_zero rx, pwm1, spi mosi
// - p1.7: touch 19, enhanced tx, uart_zero tx, pwm0; bit 3 unused
// - p2.0: touch 15, sda, slave2 sda, buzzer, miso, timer1 input
// - p2.1: touch 16, scl, slave2 scl, buzzer, sck, timer2 input
// - p2.2: touch 17, rx routes, pwm1, mosi, timer2 external input
// - p2.3: touch 18, tx routes, pwm0, spi select, timer0 input
// - every register reads back what was written less its unused bits, resets to zero
module pfs_pin_function_select #(
	parameter int NPIN = pfs_pkg::NPIN,
	parameter int AW   = pfs_pkg::AW
) (
	// clock, reset, clock enable
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            pclk_en,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [AW-1:0]   paddr,
	input  wire logic [31:0]     pwdata,
	output logic                 pready,
	output logic [31:0]          prdata,
	output logic                 pslverr,
	// pads
	input  wire logic [NPIN-1:0] pad_in,
	output logic [NPIN-1:0]      pad_out,
	output logic [NPIN-1:0]      pad_oe,
	input  wire logic [NPIN-1:0] analog_pad_on,
	output logic [NPIN-1:0]      touch_key_sense_on,
	// general io
	input  wire logic [NPIN-1:0] gpio_out,
	input  wire logic [NPIN-1:0] gpio_oe,
	output logic [NPIN-1:0]      gpio_in,
	// pin interrupt sources
	output logic                 pin_irq_zero,
	output logic                 pin_irq_one,
	// uarts
	input  wire logic            uart_zero_tx,
	input  wire logic            enhanced_uart_tx,
	output logic                 uart_zero_rx,
	output logic                 enhanced_uart_rx,
	// i2c, open drain: a low output pulls the line
	input  wire logic            i2c_master_sda_out,
	input  wire logic            i2c_master_scl_out,
	input  wire logic            i2c_slave2_sda_out,
	input  wire logic            i2c_slave2_scl_out,
	output logic                 i2c_master_sda_in,
	output logic                 i2c_master_scl_in,
	output logic                 i2c_slave2_sda_in,
	output logic                 i2c_slave2_scl_in,
	// pwm, buzzer, capture/compare
	input  wire logic            pwm_ch0_out,
	input  wire logic            pwm_ch1_out,
	input  wire logic            buzzer_out,
	input  wire logic            capcomp_ch5_out,
	input  wire logic            capcomp_ch5_oe,
	output logic                 capcomp_ch5_in,
	// spi
	input  wire logic            spi_mosi_out,
	input  wire logic            spi_mosi_oe,
	input  wire logic            spi_miso_out,
	input  wire logic            spi_miso_oe,
	input  wire logic            spi_sck_out,
	input  wire logic            spi_sck_oe,
	output logic                 spi_mosi_in,
	output logic                 spi_miso_in,
	output logic                 spi_sck_in,
	output logic                 spi_ssn_in,
	// timer inputs
	output logic                 timer_zero_in,
	output logic                 timer_one_in,
	output logic                 timer_two_in,
	output logic                 timer_two_ex_in
);

	// one bit column across all pin registers
	function automatic logic [NPIN-1:0] column(
		input logic [7:0] r [NPIN],
		input int         b
	);
		logic [NPIN-1:0] c;
		c = '0;
		for (int i = 0; i < NPIN; i++) begin
			c[i] = r[i][b];
		end
		return c;
	endfunction

	// input routing: OR of selected pads, idle level when none chosen
	function automatic logic pick(
		input logic [NPIN-1:0] sel,
		input logic [NPIN-1:0] pads,
		input logic            idle
	);
		return (sel == '0) ? idle : |(sel & pads);
	endfunction

	function automatic logic [7:0] wmask(input int s);
		if (s == 6) begin
			return pfs_pkg::WMASK_P1_7;
		end
		if (pfs_pkg::PORT2_PINS[s]) begin
			return pfs_pkg::WMASK_P2;
		end
		return pfs_pkg::WMASK_FULL;
	endfunction

	logic [7:0]          cfg_reg [NPIN];
	pfs_pkg::pfs_phase_t phase_reg;

	// address decode
	logic [NPIN-1:0] hit;
	logic            hit_any;
	logic [7:0]      rd_byte;

	always_comb begin
		hit = '0;
		rd_byte = 8'h00;
		for (int i = 0; i < NPIN; i++) begin
			hit[i] = (paddr[1:0] == 2'b00) &&
				(paddr[AW-1:2] == pfs_pkg::REG_IDX[i]);
			if (hit[i]) begin
				rd_byte = cfg_reg[i];
			end
		end
	end
	assign hit_any = |hit;

	wire access  = psel && penable;
	wire wr_take = access && pwrite && (phase_reg == pfs_pkg::PFS_ANSWER);

	// apb answer: one wait state, write lands at the pready edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= pfs_pkg::PFS_IDLE;
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (pclk_en) begin
			case (phase_reg)
			pfs_pkg::PFS_IDLE: begin
				if (access) begin
					phase_reg <= pfs_pkg::PFS_ANSWER;
					pready <= 1'b1;
					pslverr <= !hit_any;
					prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				end
			end
			pfs_pkg::PFS_ANSWER: begin
				phase_reg <= pfs_pkg::PFS_IDLE;
				pready <= 1'b0;
				pslverr <= 1'b0;
				prdata <= 32'h0000_0000;
			end
			default: begin
				phase_reg <= pfs_pkg::PFS_IDLE;
				pready <= 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NPIN; i++) begin
				cfg_reg[i] <= pfs_pkg::REG_RST;
			end
		end else if (pclk_en && wr_take) begin
			for (int i = 0; i < NPIN; i++) begin
				if (hit[i]) begin
					cfg_reg[i] <= pwdata[7:0] & wmask(i);
				end
			end
		end
	end

	// function select columns
	wire [NPIN-1:0] c0 = column(cfg_reg, pfs_pkg::BIT_GPIO);
	wire [NPIN-1:0] c1 = column(cfg_reg, pfs_pkg::BIT_IRQ0);
	wire [NPIN-1:0] c2 = column(cfg_reg, pfs_pkg::BIT_IRQ1);
	wire [NPIN-1:0] c3 = column(cfg_reg, pfs_pkg::BIT_F3);
	wire [NPIN-1:0] c4 = column(cfg_reg, pfs_pkg::BIT_F4);
	wire [NPIN-1:0] c5 = column(cfg_reg, pfs_pkg::BIT_F5);
	wire [NPIN-1:0] c6 = column(cfg_reg, pfs_pkg::BIT_F6);
	wire [NPIN-1:0] c7 = column(cfg_reg, pfs_pkg::BIT_TOUCH);

	wire [NPIN-1:0] general_io_function_on = c0;
	wire [NPIN-1:0] pin_irq_zero_source_on = c1 & pfs_pkg::PORT1_PINS;
	wire [NPIN-1:0] pin_irq_one_source_on  = c2 & pfs_pkg::PORT1_PINS;
	wire [NPIN-1:0] timer_col = column(cfg_reg, pfs_pkg::BIT_TIMER) &
		pfs_pkg::PORT2_PINS;

	wire [NPIN-1:0] enh_uart_tx_route      = c6 & pfs_pkg::M6_ETX;
	wire [NPIN-1:0] uart_zero_tx_route     = c5 & pfs_pkg::M6_ETX;
	wire [NPIN-1:0] enh_uart_rx_route      = c6 & pfs_pkg::M6_ERX;
	wire [NPIN-1:0] uart_zero_rx_route     = c5 & pfs_pkg::M6_ERX;
	wire [NPIN-1:0] i2c_master_data_route  = c6 & pfs_pkg::M6_MSDA;
	wire [NPIN-1:0] i2c_slave2_data_route  = c5 & pfs_pkg::M6_MSDA;
	wire [NPIN-1:0] i2c_master_clock_route = c6 & pfs_pkg::M6_MSCL;
	wire [NPIN-1:0] i2c_slave2_clock_route = c5 & pfs_pkg::M6_MSCL;
	wire [NPIN-1:0] capcomp_ch5_io_route   = c4 & pfs_pkg::M4_CAPCOMP_CHANNEL_FIVE;
	wire [NPIN-1:0] pulse_ch0_out_route    = c4 & pfs_pkg::M4_PWM0;
	wire [NPIN-1:0] pulse_ch1_out_route    = c4 & pfs_pkg::M4_PWM1;
	wire [NPIN-1:0] buzzer_out_route       = c4 & pfs_pkg::M4_BZ;
	wire [NPIN-1:0] spi_slave_select_route = c3 & pfs_pkg::M3_SSN;
	wire [NPIN-1:0] spi_mosi_route         = c3 & pfs_pkg::M3_MOSI;
	wire [NPIN-1:0] spi_miso_route         = c3 & pfs_pkg::M3_MISO;
	wire [NPIN-1:0] spi_clock_route        = c3 & pfs_pkg::M3_SCK;
	wire [NPIN-1:0] timer_zero_input_route = timer_col & pfs_pkg::M1_T0;
	wire [NPIN-1:0] timer_one_input_route  = timer_col & pfs_pkg::M1_T1;
	wire [NPIN-1:0] timer_two_input_route  = timer_col & pfs_pkg::M1_T2;
	wire [NPIN-1:0] timer_two_external_route = timer_col & pfs_pkg::M1_T2EX;

	wire [NPIN-1:0] touch_next = c7 & analog_pad_on;

	// pad drive; the fixed order below only settles overlaps that
	// software is not meant to create
	logic [NPIN-1:0] pad_out_next;
	logic [NPIN-1:0] pad_oe_next;

	always_comb begin
		pad_out_next = '0;
		pad_oe_next = '0;
		for (int i = 0; i < NPIN; i++) begin
			if (touch_next[i]) begin
				pad_oe_next[i] = 1'b0;
			end else if (i2c_master_data_route[i]) begin
				pad_oe_next[i] = !i2c_master_sda_out;
			end else if (i2c_master_clock_route[i]) begin
				pad_oe_next[i] = !i2c_master_scl_out;
			end else if (i2c_slave2_data_route[i]) begin
				pad_oe_next[i] = !i2c_slave2_sda_out;
			end else if (i2c_slave2_clock_route[i]) begin
				pad_oe_next[i] = !i2c_slave2_scl_out;
			end else if (enh_uart_tx_route[i]) begin
				pad_out_next[i] = enhanced_uart_tx;
				pad_oe_next[i] = 1'b1;
			end else if (uart_zero_tx_route[i]) begin
				pad_out_next[i] = uart_zero_tx;
				pad_oe_next[i] = 1'b1;
			end else if (capcomp_ch5_io_route[i]) begin
				pad_out_next[i] = capcomp_ch5_out;
				pad_oe_next[i] = capcomp_ch5_oe;
			end else if (pulse_ch0_out_route[i]) begin
				pad_out_next[i] = pwm_ch0_out;
				pad_oe_next[i] = 1'b1;
			end else if (pulse_ch1_out_route[i]) begin
				pad_out_next[i] = pwm_ch1_out;
				pad_oe_next[i] = 1'b1;
			end else if (buzzer_out_route[i]) begin
				pad_out_next[i] = buzzer_out;
				pad_oe_next[i] = 1'b1;
			end else if (spi_mosi_route[i]) begin
				pad_out_next[i] = spi_mosi_out;
				pad_oe_next[i] = spi_mosi_oe;
			end else if (spi_miso_route[i]) begin
				pad_out_next[i] = spi_miso_out;
				pad_oe_next[i] = spi_miso_oe;
			end else if (spi_clock_route[i]) begin
				pad_out_next[i] = spi_sck_out;
				pad_oe_next[i] = spi_sck_oe;
			end else if (general_io_function_on[i]) begin
				pad_out_next[i] = gpio_out[i];
				pad_oe_next[i] = gpio_oe[i];
			end
		end
	end

	// all outputs registered; this adds one cycle of pad latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out <= '0;
			pad_oe <= '0;
			touch_key_sense_on <= '0;
			gpio_in <= '0;
			pin_irq_zero <= 1'b0;
			pin_irq_one <= 1'b0;
		end else if (pclk_en) begin
			pad_out <= pad_out_next;
			pad_oe <= pad_oe_next;
			touch_key_sense_on <= touch_next;
			gpio_in <= pad_in & general_io_function_on;
			pin_irq_zero <= |(pad_in & pin_irq_zero_source_on);
			pin_irq_one <= |(pad_in & pin_irq_one_source_on);
		end
	end

	// idle levels: uart and i2c lines and the spi select high, the rest low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uart_zero_rx <= 1'b1;
			enhanced_uart_rx <= 1'b1;
			i2c_master_sda_in <= 1'b1;
			i2c_master_scl_in <= 1'b1;
			i2c_slave2_sda_in <= 1'b1;
			i2c_slave2_scl_in <= 1'b1;
			spi_ssn_in <= 1'b1;
			spi_mosi_in <= 1'b0;
			spi_miso_in <= 1'b0;
			spi_sck_in <= 1'b0;
			capcomp_ch5_in <= 1'b0;
			timer_zero_in <= 1'b0;
			timer_one_in <= 1'b0;
			timer_two_in <= 1'b0;
			timer_two_ex_in <= 1'b0;
		end else if (pclk_en) begin
			uart_zero_rx <= pick(uart_zero_rx_route, pad_in, 1'b1);
			enhanced_uart_rx <= pick(enh_uart_rx_route, pad_in, 1'b1);
			i2c_master_sda_in <= pick(i2c_master_data_route, pad_in, 1'b1);
			i2c_master_scl_in <= pick(i2c_master_clock_route, pad_in, 1'b1);
			i2c_slave2_sda_in <= pick(i2c_slave2_data_route, pad_in, 1'b1);
			i2c_slave2_scl_in <= pick(i2c_slave2_clock_route, pad_in, 1'b1);
			spi_ssn_in <= pick(spi_slave_select_route, pad_in, 1'b1);
			spi_mosi_in <= pick(spi_mosi_route, pad_in, 1'b0);
			spi_miso_in <= pick(spi_miso_route, pad_in, 1'b0);
			spi_sck_in <= pick(spi_clock_route, pad_in, 1'b0);
			capcomp_ch5_in <= pick(capcomp_ch5_io_route, pad_in, 1'b0);
			timer_zero_in <= pick(timer_zero_input_route, pad_in, 1'b0);
			timer_one_in <= pick(timer_one_input_route, pad_in, 1'b0);
			timer_two_in <= pick(timer_two_input_route, pad_in, 1'b0);
			timer_two_ex_in <= pick(timer_two_external_route, pad_in,
				1'b0);
		end
	end

endmodule

// File: design/pfs_pkg.sv
package pfs_pkg;
	localparam int          NPIN     = 11;
	localparam int          AW       = 18;
	localparam logic [7:0]  REG_RST  = 8'h00;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_P1_1 = 16'ha059;
	localparam logic [15:0] IDX_P1_2 = 16'ha05a;
	localparam logic [15:0] IDX_P1_3 = 16'ha05b;
	localparam logic [15:0] IDX_P1_4 = 16'ha05c;
	localparam logic [15:0] IDX_P1_5 = 16'ha05d;
	localparam logic [15:0] IDX_P1_6 = 16'ha05e;
	localparam logic [15:0] IDX_P1_7 = 16'ha05f;
	localparam logic [15:0] IDX_P2_0 = 16'ha070;
	localparam logic [15:0] IDX_P2_1 = 16'ha071;
	localparam logic [15:0] IDX_P2_2 = 16'ha072;
	localparam logic [15:0] IDX_P2_3 = 16'ha073;
	localparam logic [15:0] REG_IDX [NPIN] = '{IDX_P1_1, IDX_P1_2,
		IDX_P1_3, IDX_P1_4, IDX_P1_5, IDX_P1_6, IDX_P1_7, IDX_P2_0,
		IDX_P2_1, IDX_P2_2, IDX_P2_3};

	// field positions
	localparam int BIT_GPIO  = 0;
	localparam int BIT_IRQ0  = 1;
	localparam int BIT_TIMER = 1;
	localparam int BIT_IRQ1  = 2;
	localparam int BIT_F3    = 3;
	localparam int BIT_F4    = 4;
	localparam int BIT_F5    = 5;
	localparam int BIT_F6    = 6;
	localparam int BIT_TOUCH = 7;

	// unused bits read as zero
	localparam logic [7:0] WMASK_FULL = 8'hff;
	localparam logic [7:0] WMASK_P1_7 = 8'hf7;
	localparam logic [7:0] WMASK_P2   = 8'hfb;

	// pin masks, bit i = slot i (p1.1 .. p1.7, p2.0 .. p2.3)
	localparam logic [NPIN-1:0] PORT1_PINS = 11'h07f;
	localparam logic [NPIN-1:0] PORT2_PINS = 11'h780;
	localparam logic [NPIN-1:0] M6_ETX  = 11'h441;
	localparam logic [NPIN-1:0] M6_MSDA = 11'h08a;
	localparam logic [NPIN-1:0] M6_MSCL = 11'h114;
	localparam logic [NPIN-1:0] M6_ERX  = 11'h220;
	localparam logic [NPIN-1:0] M4_CAPCOMP_CHANNEL_FIVE = 11'h001;
	localparam logic [NPIN-1:0] M4_PWM0 = 11'h442;
	localparam logic [NPIN-1:0] M4_PWM1 = 11'h234;
	localparam logic [NPIN-1:0] M4_BZ   = 11'h188;
	localparam logic [NPIN-1:0] M3_SSN  = 11'h405;
	localparam logic [NPIN-1:0] M3_MOSI = 11'h222;
	localparam logic [NPIN-1:0] M3_MISO = 11'h088;
	localparam logic [NPIN-1:0] M3_SCK  = 11'h110;
	localparam logic [NPIN-1:0] M1_T1   = 11'h080;
	localparam logic [NPIN-1:0] M1_T2   = 11'h100;
	localparam logic [NPIN-1:0] M1_T2EX = 11'h200;
	localparam logic [NPIN-1:0] M1_T0   = 11'h400;

	typedef enum logic {PFS_IDLE, PFS_ANSWER} pfs_phase_t;
endpackage

// File: test/pfs_far_model.sv
`timescale 1ns/1ps
// pads: a pin the block drives reads back its own level, an idle pin
// shows whatever the board puts on it
module pfs_far_model #(
	parameter int NPIN = 11
) (
	// pad side of the block
	input  wire logic [NPIN-1:0] pad_out,
	input  wire logic [NPIN-1:0] pad_oe,
	// outside level of undriven pads
	input  wire logic [NPIN-1:0] ext,
	output logic [NPIN-1:0]      pad_in
);
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule

// File: test/pfs_checker_assertions.sv
`timescale 1ns/1ps
module pfs_checker #(
	parameter int NPIN = 11
) (
	// clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// apb
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pready,
	input  wire logic            pslverr,
	input  wire logic [31:0]     prdata,
	// pads and routed inputs
	input  wire logic [NPIN-1:0] pad_in,
	input  wire logic [NPIN-1:0] pad_oe,
	input  wire logic [NPIN-1:0] analog_pad_on,
	input  wire logic [NPIN-1:0] touch_key_sense_on,
	input  wire logic [NPIN-1:0] gpio_in,
	input  wire logic            pin_irq_zero,
	input  wire logic            uart_zero_rx,
	input  wire logic            timer_zero_in,
	input  wire logic            timer_one_in
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	property p_wait; s_setup ##1 s_access |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("late answer");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
	property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_rst; $rose(presetn) |-> pad_oe == '0 && !pready; endproperty
	a_rst: assert property (p_rst) else $error("pads live at reset");
	property p_gpio; (gpio_in & ~$past(pad_in)) == '0; endproperty
	a_gpio: assert property (p_gpio) else $error("gpio in high");
	property p_irq; pin_irq_zero |-> $past(pad_in[6:0]) != 7'h00; endproperty
	a_irq: assert property (p_irq) else $error("irq without pad");
	property p_tch;
		(touch_key_sense_on & ~$past(analog_pad_on)) == '0;
	endproperty
	a_tch: assert property (p_tch) else $error("touch w/o analog");
	property p_rx;
		!uart_zero_rx |-> !($past(pad_in[5]) && $past(pad_in[9]));
	endproperty
	a_rx: assert property (p_rx) else $error("rx low w/o pad");
	property p_t0; timer_zero_in |-> $past(pad_in[10]); endproperty
	a_t0: assert property (p_t0) else $error("timer0 in");
	property p_t1; timer_one_in |-> $past(pad_in[7]); endproperty
	a_t1: assert property (p_t1) else $error("timer1 in");
endmodule

bind pfs_pin_function_select pfs_checker #(.NPIN(NPIN)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .prdata(prdata),
	.pad_in(pad_in), .pad_oe(pad_oe), .analog_pad_on(analog_pad_on),
	.touch_key_sense_on(touch_key_sense_on), .gpio_in(gpio_in),
	.pin_irq_zero(pin_irq_zero), .uart_zero_rx(uart_zero_rx),
	.timer_zero_in(timer_zero_in), .timer_one_in(timer_one_in));

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int N = pfs_pkg::NPIN;
	logic              pclk    = 1'b0;
	logic              presetn = 1'b0;
	logic              psel    = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite  = 1'b0;
	logic [17:0]       paddr   = 18'h0_0000;
	logic [31:0]       pwdata  = 32'h0000_0000;
	logic [N-1:0]      ext     = '0;
	logic [N-1:0]      an      = '0;
	logic [N-1:0]      gout    = '0;
	logic [N-1:0]      goe     = '0;
	logic [16:0]       pv      = '0;
	logic [7:0]        c [N];
	logic [7:0]        q, v;
	logic [1:0]        d;
	logic              e;
	int                err_count, checked, seed, k;
	wire logic [N-1:0] pad_in, pad_out, pad_oe, tch, gin;
	wire logic [16:0]  o;
	wire logic         pready, pslverr;
	wire logic [31:0]  prdata;

	always #2 pclk = ~pclk;

	pfs_pin_function_select dut_u (
		.pclk(pclk), .presetn(presetn), .pclk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .analog_pad_on(an),
		.touch_key_sense_on(tch), .gpio_out(gout), .gpio_oe(goe),
		.gpio_in(gin), .pin_irq_zero(o[0]), .pin_irq_one(o[1]),
		.uart_zero_tx(pv[0]), .enhanced_uart_tx(pv[1]),
		.uart_zero_rx(o[2]), .enhanced_uart_rx(o[3]),
		.i2c_master_sda_out(pv[2]), .i2c_master_scl_out(pv[3]),
		.i2c_slave2_sda_out(pv[4]), .i2c_slave2_scl_out(pv[5]),
		.i2c_master_sda_in(o[4]), .i2c_master_scl_in(o[5]),
		.i2c_slave2_sda_in(o[6]), .i2c_slave2_scl_in(o[7]),
		.pwm_ch0_out(pv[6]), .pwm_ch1_out(pv[7]), .buzzer_out(pv[8]),
		.capcomp_ch5_out(pv[9]), .capcomp_ch5_oe(pv[10]),
		.capcomp_ch5_in(o[8]), .spi_mosi_out(pv[11]),
		.spi_mosi_oe(pv[12]), .spi_miso_out(pv[13]),
		.spi_miso_oe(pv[14]), .spi_sck_out(pv[15]), .spi_sck_oe(pv[16]),
		.spi_mosi_in(o[9]), .spi_miso_in(o[10]), .spi_sck_in(o[11]),
		.spi_ssn_in(o[12]), .timer_zero_in(o[13]),
		.timer_one_in(o[14]), .timer_two_in(o[15]),
		.timer_two_ex_in(o[16]));

	pfs_far_model #(.NPIN(N)) far_u (
		.pad_out(pad_out), .pad_oe(pad_oe), .ext(ext), .pad_in(pad_in));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// the request stands until the rising edge that samples pready high;
	// read data and the error flag are taken at that same edge
	task automatic apb(input logic w, input logic [15:0] x,
		input logic [7:0] dat);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {x, 2'b00};
		pwdata <= {24'h00_0000, dat};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			chk(0, 1);
			test_done;
		end else begin
			q = prdata[7:0];
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	function automatic logic [N-1:0] sel(int b);
		logic [N-1:0] s;
		for (int i = 0; i < N; i++)
			s[i] = c[i][b];
		return s;
	endfunction

	function automatic logic fin(logic [N-1:0] m, int b, logic idle);
		logic [N-1:0] s;
		s = sel(b) & m;
		return (s != '0) ? |(s & pad_in) : idle;
	endfunction

	function automatic logic [1:0] drv(int i);
		logic [N-1:0] m;
		logic         h;
		m = N'(1) << i;
		h = c[i][6];
		if (c[i][7])
			return 2'b00;
		if (h | c[i][5]) begin
			if (|(m & pfs_pkg::M6_ETX))
				return {1'b1, h ? pv[1] : pv[0]};
			if (|(m & pfs_pkg::M6_MSDA))
				return {h ? ~pv[2] : ~pv[4], 1'b0};
			if (|(m & pfs_pkg::M6_MSCL))
				return {h ? ~pv[3] : ~pv[5], 1'b0};
			return 2'b00;
		end
		if (c[i][4]) begin
			if (|(m & pfs_pkg::M4_CAPCOMP_CHANNEL_FIVE))
				return pv[10:9];
			if (|(m & pfs_pkg::M4_BZ))
				return {1'b1, pv[8]};
			return {1'b1, |(m & pfs_pkg::M4_PWM0) ? pv[6] : pv[7]};
		end
		if (c[i][3]) begin
			if (|(m & pfs_pkg::M3_MOSI))
				return pv[12:11];
			if (|(m & pfs_pkg::M3_MISO))
				return pv[14:13];
			if (|(m & pfs_pkg::M3_SCK))
				return pv[16:15];
			return 2'b00;
		end
		return c[i][0] ? {goe[i], gout[i]} : 2'b00;
	endfunction

	initial begin
		repeat (100000) @(posedge pclk);
		chk(0, 1);
		test_done;
	end

	initial begin
		seed = 32'h0b0f_a183;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < N; i++) begin
			apb(1'b0, pfs_pkg::REG_IDX[i], 8'h00);
			chk(32'({e, q}), 32'({1'b0, pfs_pkg::REG_RST}));
		end
		apb(1'b1, 16'ha060, 8'hff);
		apb(1'b0, 16'ha060, 8'h00);
		chk(32'({e, q}), 32'h0000_0100);
		repeat (40) begin
			for (int i = 0; i < N; i++) begin
				v = 8'($random(seed));
				k = {$random(seed)} % 6;
				// one driving function per pin: order among several is open
				v = (k < 5) ? ((v & 8'h06) | (8'h08 << k)) : (v & 8'h07);
				c[i] = v & ((i == 6) ? 8'hf7 : (i > 6) ? 8'hfb : 8'hff);
				apb(1'b1, pfs_pkg::REG_IDX[i], v);
			end
			{ext, an, gout, goe} <= 44'({$random(seed), $random(seed)});
			pv <= 17'($random(seed));
			for (int i = 0; i < N; i++) begin
				apb(1'b0, pfs_pkg::REG_IDX[i], 8'h00);
				chk(32'({e, q}), 32'({1'b0, c[i]}));
			end
			@(negedge pclk);
			chk(32'(gin), 32'(sel(0) & pad_in));
			chk(32'(tch), 32'(sel(7) & an));
			chk(32'(o[1:0]), 32'({fin(pfs_pkg::PORT1_PINS, 2, 1'b0),
				fin(pfs_pkg::PORT1_PINS, 1, 1'b0)}));
			chk(32'(o[3:2]), 32'({fin(pfs_pkg::M6_ERX, 6, 1'b1),
				fin(pfs_pkg::M6_ERX, 5, 1'b1)}));
			chk(32'(o[7:4]), 32'({fin(pfs_pkg::M6_MSCL, 5, 1'b1),
				fin(pfs_pkg::M6_MSDA, 5, 1'b1), fin(pfs_pkg::M6_MSCL, 6, 1'b1),
				fin(pfs_pkg::M6_MSDA, 6, 1'b1)}));
			chk(32'(o[12:8]), 32'({fin(pfs_pkg::M3_SSN, 3, 1'b1),
				fin(pfs_pkg::M3_SCK, 3, 1'b0), fin(pfs_pkg::M3_MISO, 3, 1'b0),
				fin(pfs_pkg::M3_MOSI, 3, 1'b0),
				fin(pfs_pkg::M4_CAPCOMP_CHANNEL_FIVE, 4, 1'b0)}));
			chk(32'(o[16:13]), 32'({fin(pfs_pkg::M1_T2EX, 1, 1'b0),
				fin(pfs_pkg::M1_T2, 1, 1'b0), fin(pfs_pkg::M1_T1, 1, 1'b0),
				fin(pfs_pkg::M1_T0, 1, 1'b0)}));
			for (int i = 0; i < N; i++) begin
				d = drv(i);
				chk(32'({pad_oe[i], pad_oe[i] & pad_out[i]}),
					32'(d & {1'b1, d[1]}));
			end
		end
		test_done;
	end
endmodule
